// file: hpb_cfg.svh
// Constants for the host port buffer access block
// How it works
// - Host address selects one endpoint buffer
// - Host picks DMA request or interrupt notification
// - DMA request asserts while a buffer is ready and not acknowledged
// - Interrupt raised on buffer status change to ready
// - Synchronous transfers: 33 MHz, 16-bit data
// - Masked status sources never raise interrupt
// - Port runs as cellular RAM, SRAM, NAND, serial
// - Status reports address of buffer ready to read
`ifndef HPB_CFG_SVH
`define HPB_CFG_SVH

`define DATA_W          16
`define ADDR_W          8
`define FIFO_DEPTH      32
`define SRC_N           2
`define HOST_SYNC_MHZ   33

// Word addresses seen by the host
`define EP_OUT_ADDR     8'h00
`define EP_IN_ADDR      8'h01
`define CFG_ADDR        8'h10
`define STAT_ADDR       8'h11
`define RDY_ADDR        8'h12
`define NO_BUF_ADDR     8'hff

// Status source positions, config and status fields
`define SRC_OUT_ROOM    0
`define SRC_IN_DATA     1
`define CFG_IRQ_BIT     0
`define CFG_MASK_LSB    4
`define STAT_EV_LSB     2
`define CFG_RST         16'h0000

// Bus style codes on the strap input
`define MODE_MUX_SYNC   3'h0
`define MODE_MUX_ASYNC  3'h1
`define MODE_CRAM_SYNC  3'h2
`define MODE_CRAM_ASYNC 3'h3
`define MODE_SRAM       3'h4
`define MODE_NAND       3'h5
`define MODE_SERIAL     3'h6

// Serial frame: 8 header bits (read flag, 7-bit address), 16 data bits
`define SER_HDR_LAST    4'h7
`define SER_DATA_LAST   4'hf
`define SER_ADDR_PAD    1'h0

`endif

// file: hpb_fifo.sv
// Parameterised word FIFO with valid/ready on both sides
module hpb_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	localparam logic [AW:0]   FULL = (AW + 1)'(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	assign in_ready_out  = (cnt_r != FULL);
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem[rd_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_ready_in && out_valid_out;

	always_comb begin
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
		end
		if (pop) begin
			rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_r] <= in_data_in;
		end
	end

	fill_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
		cnt_r <= FULL)
		else $error("fifo level beyond depth");
endmodule

// file: hpb_host_model.sv
// Host processor model driving the SRAM-style bus, asynchronously or on the host clock
module hpb_host_model (
	input  wire logic        clk_in,
	output logic             ce_n_out,
	output logic             we_n_out,
	output logic             oe_n_out,
	output logic [7:0]       a_out,
	output logic [15:0]      dq_out,
	output logic             hclk_out,
	input  wire logic [15:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ce_n_out = 1'b1;
		we_n_out = 1'b1;
		oe_n_out = 1'b1;
		a_out = 8'h00;
		dq_out = 16'h0000;
		hclk_out = 1'b0;
	end

	// Synchronous styles: one word on a single host clock rise
	task automatic sync_acc(input logic w, input logic [7:0] a,
			input logic [15:0] din, output logic [15:0] d);
		@(posedge clk_in);
		ce_n_out <= 1'b0;
		we_n_out <= !w;
		oe_n_out <= w;
		a_out <= a;
		dq_out <= din;
		repeat (2) @(posedge clk_in);
		hclk_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		d = dq_in;
		hclk_out <= 1'b0;
		ce_n_out <= 1'b1;
		we_n_out <= 1'b1;
		oe_n_out <= 1'b1;
	endtask

	// One 16-bit word per strobe; strobe held two samples, gap of one
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		ce_n_out <= 1'b0;
		we_n_out <= 1'b0;
		a_out <= a;
		dq_out <= d;
		repeat (2) @(posedge clk_in);
		ce_n_out <= 1'b1;
		we_n_out <= 1'b1;
		// Released data lines must not keep showing the written word
		dq_out <= ~d;
	endtask

	// Data is taken at the third edge, well after it settles
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		ce_n_out <= 1'b0;
		oe_n_out <= 1'b0;
		a_out <= a;
		repeat (3) @(posedge clk_in);
		d = dq_in;
		ce_n_out <= 1'b1;
		oe_n_out <= 1'b1;
	endtask
endmodule

// file: hpb_host_port.sv
// Host memory port: bus decode, endpoint buffers, config and status
`include "hpb_cfg.svh"
module hpb_host_port
	import hpb_pkg::*;
(
	input  wire logic              CLK_IN,
	input  wire logic              RST_IN,
	input  wire logic [2:0]        MODE_IN,
	input  wire logic              HCLK_IN,
	input  wire logic              CE_N_IN,
	input  wire logic              WE_N_IN,
	input  wire logic              OE_N_IN,
	input  wire logic              ADV_N_IN,
	input  wire logic [`ADDR_W-1:0] A_IN,
	input  wire logic [`DATA_W-1:0] DQ_IN,
	output logic      [`DATA_W-1:0] DQ_OUT,
	output logic      [`DATA_W-1:0] DQ_OE_OUT,
	output logic                   INT_N_OUT,
	output logic                   DRQ_N_OUT,
	input  wire logic              DACK_N_IN,
	output word_s                  RX_OUT,
	output logic                   RX_VALID_OUT,
	input  wire logic              RX_READY_IN,
	input  wire word_s             TX_IN,
	input  wire logic              TX_VALID_IN,
	output logic                   TX_READY_OUT
);
	bus_mode_e          mode_r, mode_nxt;
	pins_s              pin_r, pin_nxt;
	ser_s               ser_r, ser_nxt;
	logic [`ADDR_W-1:0] addr_r, addr_nxt;
	logic [`DATA_W-1:0] cfg_r, cfg_nxt;
	logic [`DATA_W-1:0] rdata_r, rdata_nxt;
	logic [`SRC_N-1:0]  ev_r, ev_nxt, rdy_r, rdy, clr, mask;
	logic               irq_r, irq_nxt, drq_r, drq_nxt;

	logic ce, we, oe, adv, cle, hclk_rise, hclk_fall;
	logic sync_m, mux_m, nand_m, ser_m;
	logic par_wr, par_rd, acc_wr, acc_rd;
	logic [`ADDR_W-1:0] acc_addr;
	logic [`DATA_W-1:0] acc_wdata, rd_val;
	logic ser_edge, ser_hdr_done, ser_data_done, ser_wr, ser_rd;
	logic [`ADDR_W-1:0] ser_hdr;
	logic rx_in_ready, tx_out_valid, rx_push, tx_pop;
	word_s tx_head;

	// Strap is taken while reset is held, then frozen
	always_comb begin
		mode_nxt = mode_r;
		if (RST_IN) begin
			unique case (MODE_IN)
				`MODE_MUX_SYNC:   mode_nxt = BM_MUX_SYNC;
				`MODE_MUX_ASYNC:  mode_nxt = BM_MUX_ASYNC;
				`MODE_CRAM_SYNC:  mode_nxt = BM_CRAM_SYNC;
				`MODE_CRAM_ASYNC: mode_nxt = BM_CRAM_ASYNC;
				`MODE_SRAM:       mode_nxt = BM_SRAM;
				`MODE_NAND:       mode_nxt = BM_NAND;
				`MODE_SERIAL:     mode_nxt = BM_SERIAL;
				default:          mode_nxt = BM_CRAM_ASYNC;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		mode_r <= mode_nxt;
	end

	assign ce     = !CE_N_IN;
	assign we     = !WE_N_IN;
	assign oe     = !OE_N_IN;
	assign adv    = !ADV_N_IN;
	assign cle    = A_IN[0];
	assign sync_m = (mode_r == BM_MUX_SYNC) || (mode_r == BM_CRAM_SYNC);
	assign mux_m  = (mode_r == BM_MUX_SYNC) || (mode_r == BM_MUX_ASYNC);
	assign nand_m = (mode_r == BM_NAND);
	assign ser_m  = (mode_r == BM_SERIAL);
	assign hclk_rise = HCLK_IN && !pin_r.hclk;
	assign hclk_fall = !HCLK_IN && pin_r.hclk;

	// Parallel styles synchronous ones move one 16-bit word per
	// rising host clock edge
	always_comb begin
		par_wr = 1'b0;
		par_rd = 1'b0;
		if (sync_m) begin
			par_wr = hclk_rise && ce && !adv && we;
			par_rd = hclk_rise && ce && !adv && oe && !we;
		end else if (!ser_m) begin
			par_wr = ce && we && !pin_r.we && !adv && !(nand_m && cle);
			par_rd = ce && oe && !pin_r.oe && !adv;
		end
	end

	// Muxed styles latch the address off DQ; the NAND style takes it
	// from command or address cycles
	always_comb begin
		addr_nxt = addr_r;
		if (mux_m && ce && adv) begin
			addr_nxt = DQ_IN[`ADDR_W-1:0];
		end else if (nand_m && ce && we && !pin_r.we && (cle || adv)) begin
			addr_nxt = DQ_IN[`ADDR_W-1:0];
		end
	end

	// Serial slave: SCK on HCLK, select on CE, SDI on DQ0, SDO on DQ1
	assign ser_edge      = ser_m && ce && hclk_rise;
	assign ser_hdr       = {ser_r.sh[`ADDR_W-2:0], DQ_IN[0]};
	assign ser_hdr_done  = ser_edge && (ser_r.st == SER_HDR) &&
	                       (ser_r.cnt == `SER_HDR_LAST);
	assign ser_data_done = ser_edge && (ser_r.st == SER_DATA) &&
	                       (ser_r.cnt == `SER_DATA_LAST);
	assign ser_rd        = ser_hdr_done && ser_hdr[`ADDR_W-1];
	assign ser_wr        = ser_data_done && !ser_r.rd;

	always_comb begin
		ser_nxt = ser_r;
		unique case (ser_r.st)
			SER_IDLE: begin
				if (ser_m && ce) begin
					ser_nxt.st  = SER_HDR;
					ser_nxt.cnt = '0;
				end
			end
			SER_HDR: begin
				if (ser_edge) begin
					ser_nxt.sh  = {ser_r.sh[`DATA_W-2:0], DQ_IN[0]};
					ser_nxt.cnt = ser_r.cnt + 1'b1;
				end
				if (ser_hdr_done) begin
					ser_nxt.st   = SER_DATA;
					ser_nxt.cnt  = '0;
					ser_nxt.rd   = ser_hdr[`ADDR_W-1];
					ser_nxt.addr = {`SER_ADDR_PAD, ser_hdr[`ADDR_W-2:0]};
					if (ser_rd) begin
						ser_nxt.sh = rd_val;
					end
				end
			end
			SER_DATA: begin
				if (ser_edge) begin
					ser_nxt.cnt = ser_r.cnt + 1'b1;
					if (!ser_r.rd) begin
						ser_nxt.sh = {ser_r.sh[`DATA_W-2:0], DQ_IN[0]};
					end
				end else if (hclk_fall && ce && ser_r.rd) begin
					ser_nxt.sh = {ser_r.sh[`DATA_W-2:0], 1'b0};
				end
				if (ser_data_done) begin
					ser_nxt.st  = SER_HDR;
					ser_nxt.cnt = '0;
				end
			end
		endcase
		if (!ser_m || !ce) begin
			ser_nxt.st  = SER_IDLE;
			ser_nxt.cnt = '0;
		end
	end

	assign acc_wr    = ser_m ? ser_wr : par_wr;
	assign acc_rd    = ser_m ? ser_rd : par_rd;
	assign acc_addr  = ser_m ? (ser_rd ? {`SER_ADDR_PAD,
	                   ser_hdr[`ADDR_W-2:0]} : ser_r.addr) :
	                   ((mux_m || nand_m) ? addr_r : A_IN);
	assign acc_wdata = ser_m ? {ser_r.sh[`DATA_W-2:0], DQ_IN[0]} : DQ_IN;

	// Host address decode onto the two endpoint buffers
	assign rx_push = acc_wr && (acc_addr == `EP_OUT_ADDR);
	assign tx_pop  = acc_rd && (acc_addr == `EP_IN_ADDR);

	// Readiness levels fall only when the host fills or drains
	assign rdy[`SRC_OUT_ROOM] = rx_in_ready;
	assign rdy[`SRC_IN_DATA]  = tx_out_valid;
	assign mask = cfg_r[`CFG_MASK_LSB +: `SRC_N];
	assign clr  = (acc_wr && acc_addr == `STAT_ADDR) ?
	              acc_wdata[`STAT_EV_LSB +: `SRC_N] : '0;

	always_comb begin
		unique case (acc_addr)
			`EP_IN_ADDR: rd_val = tx_out_valid ? tx_head.data : '0;
			`CFG_ADDR:   rd_val = cfg_r;
			`STAT_ADDR:  rd_val = {{(`DATA_W-2*`SRC_N){1'b0}}, ev_r, rdy};
			`RDY_ADDR:   rd_val = {{(`DATA_W-`ADDR_W){1'b0}},
			                      tx_out_valid ? `EP_IN_ADDR : `NO_BUF_ADDR};
			default:     rd_val = '0;
		endcase
	end

	always_comb begin
		pin_nxt   = '{hclk: HCLK_IN, we: we, oe: oe};
		cfg_nxt   = (acc_wr && acc_addr == `CFG_ADDR) ? acc_wdata : cfg_r;
		rdata_nxt = (acc_rd && !ser_m) ? rd_val : rdata_r;
		// A change landing with its clear stays set
		ev_nxt    = (ev_r & ~clr) | (rdy & ~rdy_r);
		irq_nxt   = cfg_r[`CFG_IRQ_BIT] && |(ev_nxt & ~mask);
		drq_nxt   = !cfg_r[`CFG_IRQ_BIT] && |rdy && DACK_N_IN;
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_r   <= '0;
			ser_r   <= '{st: SER_IDLE, cnt: '0, sh: '0, rd: 1'b0, addr: '0};
			addr_r  <= '0;
			cfg_r   <= `CFG_RST;
			rdata_r <= '0;
			ev_r    <= '0;
			rdy_r   <= '0;
			irq_r   <= 1'b0;
			drq_r   <= 1'b0;
		end else begin
			pin_r   <= pin_nxt;
			ser_r   <= ser_nxt;
			addr_r  <= addr_nxt;
			cfg_r   <= cfg_nxt;
			rdata_r <= rdata_nxt;
			ev_r    <= ev_nxt;
			rdy_r   <= rdy;
			irq_r   <= irq_nxt;
			drq_r   <= drq_nxt;
		end
	end

	// A write into a full buffer is dropped; software must poll first
	hpb_fifo #(.W(`DATA_W), .D(`FIFO_DEPTH)) rx_fifo (
		.clk_in        (CLK_IN),
		.rst_in        (RST_IN),
		.in_valid_in   (rx_push),
		.in_data_in    (acc_wdata),
		.in_ready_out  (rx_in_ready),
		.out_valid_out (RX_VALID_OUT),
		.out_data_out  (RX_OUT.data),
		.out_ready_in  (RX_READY_IN)
	);

	hpb_fifo #(.W(`DATA_W), .D(`FIFO_DEPTH)) tx_fifo (
		.clk_in        (CLK_IN),
		.rst_in        (RST_IN),
		.in_valid_in   (TX_VALID_IN),
		.in_data_in    (TX_IN.data),
		.in_ready_out  (TX_READY_OUT),
		.out_valid_out (tx_out_valid),
		.out_data_out  (tx_head.data),
		.out_ready_in  (tx_pop)
	);

	assign DQ_OUT    = ser_m ? {{(`DATA_W-2){1'b0}}, ser_r.sh[`DATA_W-1],
	                   1'b0} : rdata_r;
	assign DQ_OE_OUT = ser_m ? {{(`DATA_W-2){1'b0}}, ce, 1'b0} :
	                   {`DATA_W{ce && oe && !we}};
	assign INT_N_OUT = !irq_r;
	assign DRQ_N_OUT = !drq_r;

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence host_read_s;
		acc_rd && !ser_m && acc_addr == `STAT_ADDR;
	endsequence

	sequence host_push_s;
		rx_push && rx_in_ready;
	endsequence

	drq_follows_ready_a: assert property (
		!cfg_r[`CFG_IRQ_BIT] && |rdy && DACK_N_IN |=> !DRQ_N_OUT)
		else $error("dma request missing for ready buffer");

	// The request register sat in reset one cycle ago, so skip that edge
	irq_mode_only_a: assert property (
		!$past(RST_IN) && !$past(cfg_r[`CFG_IRQ_BIT])
		|-> INT_N_OUT && (cfg_r[`CFG_IRQ_BIT]
		|| !DRQ_N_OUT || !$past(|rdy && DACK_N_IN)))
		else $error("notification mode not honoured");

	irq_masked_a: assert property (
		!INT_N_OUT |-> |(ev_r & ~$past(mask)))
		else $error("masked source raised interrupt");

	ev_on_change_a: assert property (
		rdy[`SRC_IN_DATA] && !rdy_r[`SRC_IN_DATA] |=> ev_r[`SRC_IN_DATA])
		else $error("status change not recorded");

	ev_sticky_a: assert property (
		ev_r[`SRC_IN_DATA] && !clr[`SRC_IN_DATA] |=> ev_r[`SRC_IN_DATA])
		else $error("status bit dropped without clear");

	ready_addr_a: assert property (
		tx_out_valid && acc_rd && !ser_m && acc_addr == `RDY_ADDR
		|=> rdata_r[`ADDR_W-1:0] == `EP_IN_ADDR)
		else $error("ready buffer address wrong");

	status_read_a: assert property (
		host_read_s |=> rdata_r[`SRC_N-1:0] == $past(rdy))
		else $error("status read does not show readiness");

	push_reaches_a: assert property (
		rx_push && !RX_VALID_OUT
		|=> RX_VALID_OUT && RX_OUT.data == $past(acc_wdata))
		else $error("host write lost in buffer");

	push_visible_a: assert property (
		host_push_s |=> RX_VALID_OUT)
		else $error("host write did not reach buffer");

	mode_frozen_a: assert property (
		##1 1'b1 |-> $stable(mode_r))
		else $error("bus style changed outside reset");

	sync_edge_a: assert property (
		par_wr && sync_m |-> hclk_rise && $past(!HCLK_IN))
		else $error("synchronous write off host clock edge");
endmodule

// file: hpb_host_port_tb.sv
// Self-checking bench for the host port buffer access block
`include "hpb_cfg.svh"
module hpb_host_port_tb
	import hpb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(nm, ex, got) \
	begin \
		total_checks++; \
		if ((got) !== (ex)) begin \
			n_errors++; \
			$display("wrong value %s exp %h got %h", nm, ex, got); \
		end \
	end

	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [15:0] d;
	} row_s;

	logic        clk;
	logic        hclk;
	logic [2:0]  mode_sel;
	logic        rst;
	logic        ce_n, we_n, oe_n, int_n, drq_n, dack_n;
	logic        rxv, rxr, txv, txr;
	logic [7:0]  a;
	logic [15:0] hdq, dqo, dqoe, dq_w, rd;
	word_s       rxd, txd;
	int          n_errors = 0;
	int          total_checks = 0;
	int          n;

	row_s rows [7] = '{
		'{1'b1, `CFG_ADDR, 16'h0000},
		'{1'b0, `CFG_ADDR, 16'h0000},
		'{1'b0, `RDY_ADDR, 16'h00ff},
		'{1'b0, `EP_IN_ADDR, 16'h0000},
		'{1'b0, 8'h55, 16'h0000},
		'{1'b1, 8'h55, 16'h1234},
		'{1'b0, 8'h55, 16'h0000}
	};

	// Shared data wire: device drives a bit only where its enable is high
	assign dq_w = (dqoe & dqo) | (~dqoe & hdq);

	hpb_host_model host_u (
		.clk_in   (clk),
		.ce_n_out (ce_n),
		.we_n_out (we_n),
		.oe_n_out (oe_n),
		.a_out    (a),
		.dq_out   (hdq),
		.hclk_out (hclk),
		.dq_in    (dq_w)
	);

	hpb_host_port dut_u (
		.CLK_IN       (clk),
		.RST_IN       (rst),
		.MODE_IN      (mode_sel),
		.HCLK_IN      (hclk),
		.CE_N_IN      (ce_n),
		.WE_N_IN      (we_n),
		.OE_N_IN      (oe_n),
		.ADV_N_IN     (1'b1),
		.A_IN         (a),
		.DQ_IN        (dq_w),
		.DQ_OUT       (dqo),
		.DQ_OE_OUT    (dqoe),
		.INT_N_OUT    (int_n),
		.DRQ_N_OUT    (drq_n),
		.DACK_N_IN    (dack_n),
		.RX_OUT       (rxd),
		.RX_VALID_OUT (rxv),
		.RX_READY_IN  (rxr),
		.TX_IN        (txd),
		.TX_VALID_IN  (txv),
		.TX_READY_OUT (txr)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic push(input logic [15:0] d);
		@(posedge clk);
		txv <= 1'b1;
		txd.data <= d;
		@(posedge clk);
		while (txr !== 1'b1)
			@(posedge clk);
		txv <= 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		#160000;
		n_errors++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		mode_sel = `MODE_SRAM;
		rxr = 1'b0;
		txv = 1'b0;
		txd = '0;
		dack_n = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w)
				host_u.wr(rows[i].a, rows[i].d);
			else begin
				host_u.rd(rows[i].a, rd);
				`CHK("row read", rows[i].d, rd)
			end
		end
		settle();
		`CHK("drq", 1'b0, drq_n)
		dack_n <= 1'b0;
		settle();
		`CHK("drq ack", 1'b1, drq_n)
		dack_n <= 1'b1;
		push(16'h1111);
		push(16'h2222);
		host_u.rd(`RDY_ADDR, rd);
		`CHK("ready addr", 16'h0001, rd)
		host_u.rd(`EP_IN_ADDR, rd);
		`CHK("pop one", 16'h1111, rd)
		host_u.rd(`RDY_ADDR, rd);
		`CHK("ready held", 16'h0001, rd)
		host_u.rd(`EP_IN_ADDR, rd);
		`CHK("pop two", 16'h2222, rd)
		host_u.rd(`RDY_ADDR, rd);
		`CHK("none ready", 16'h00ff, rd)
		// Interrupt mode with both sources masked, then data unmasked
		host_u.wr(`STAT_ADDR, 16'h000c);
		host_u.wr(`CFG_ADDR, 16'h0031);
		push(16'h3333);
		settle();
		`CHK("int masked", 1'b1, int_n)
		`CHK("drq off", 1'b1, drq_n)
		host_u.wr(`CFG_ADDR, 16'h0011);
		settle();
		`CHK("int raised", 1'b0, int_n)
		host_u.wr(`STAT_ADDR, 16'h0008);
		settle();
		`CHK("int cleared", 1'b1, int_n)
		host_u.rd(`EP_IN_ADDR, rd);
		`CHK("pop three", 16'h3333, rd)
		// Overfill the host-write buffer while the core stalls
		host_u.wr(`CFG_ADDR, 16'h0000);
		for (int i = 0; i < 33; i++)
			host_u.wr(`EP_OUT_ADDR, 16'h0a00 + 16'(i));
		host_u.rd(`STAT_ADDR, rd);
		`CHK("full status", 2'b00, rd[1:0])
		n = 0;
		@(posedge clk);
		rxr <= 1'b1;
		repeat (40) begin
			@(posedge clk);
			if (rxv === 1'b1 && rxr === 1'b1) begin
				`CHK("rx word", 16'h0a00 + 16'(n), rxd.data)
				n++;
			end
		end
		`CHK("rx count", 32, n)
		// Second reset in a synchronous style; strap changes under reset
		mode_sel <= `MODE_CRAM_SYNC;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("dq reset", 16'h0000, dqo)
		host_u.sync_acc(1'b1, `CFG_ADDR, 16'h0031, rd);
		host_u.sync_acc(1'b0, `CFG_ADDR, 16'h0000, rd);
		`CHK("sync cfg", 16'h0031, rd)
		`CHK("sync int", 1'b1, int_n)
		final_report();
	end
endmodule

// file: hpb_pkg.sv
// Types shared by the host port buffer access block
`include "hpb_cfg.svh"
package hpb_pkg;

	typedef enum logic [6:0] {
		BM_MUX_SYNC   = 7'h01,
		BM_MUX_ASYNC  = 7'h02,
		BM_CRAM_SYNC  = 7'h04,
		BM_CRAM_ASYNC = 7'h08,
		BM_SRAM       = 7'h10,
		BM_NAND       = 7'h20,
		BM_SERIAL     = 7'h40
	} bus_mode_e;

	typedef enum logic [2:0] {
		SER_IDLE = 3'h1,
		SER_HDR  = 3'h2,
		SER_DATA = 3'h4
	} ser_state_e;

	typedef struct packed {
		logic [`DATA_W-1:0] data;
	} word_s;

	typedef struct packed {
		logic hclk;
		logic we;
		logic oe;
	} pins_s;

	typedef struct packed {
		ser_state_e         st;
		logic [3:0]         cnt;
		logic [`DATA_W-1:0] sh;
		logic               rd;
		logic [`ADDR_W-1:0] addr;
	} ser_s;

endpackage
